// ==== src/apd_regs.svh ====
// Constants shared by both ends of the converter link: offsets, fields, reset values, timing.
// Assumes a single 20 MHz pclk on both ends; counts below are in pclk cycles or conversion clocks.
`ifndef APD_REGS_SVH
`define APD_REGS_SVH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define APD_CLK_MHZ        20
`define APD_STROBE_CYC     8
`define APD_ACQ_CLKS       4'd3
`define APD_CONV_CLKS      4'd13
`define APD_INT_CONV_NS    3600
`define APD_INT_DIV        (`APD_INT_CONV_NS * `APD_CLK_MHZ / (1000 * 13))
`define APD_EXT_DIV        6
`define APD_WAKE_INT_US    500
`define APD_WAKE_EXT_US    50
`define APD_WAKE_INT_CYC   (`APD_WAKE_INT_US * `APD_CLK_MHZ)
`define APD_WAKE_EXT_CYC   (`APD_WAKE_EXT_US * `APD_CLK_MHZ)

// ---------------------------------------------------------------
// Control byte fields and power-mode codes
// ---------------------------------------------------------------
`define APD_PM_HI          7
`define APD_PM_LO          6
`define APD_POL_BIT        3
`define APD_PM_SHUT        2'b00
`define APD_PM_STBY        2'b01
`define APD_PM_INTCLK      2'b10
`define APD_PM_EXTCLK      2'b11

// ---------------------------------------------------------------
// Host register map (byte addresses) and fields
// ---------------------------------------------------------------
`define APD_CTRL_OFS       12'h000
`define APD_CMD_OFS        12'h004
`define APD_STAT_OFS       12'h008
`define APD_RES_OFS        12'h00c
`define APD_CTRL_EXTREF    8
`define APD_CTRL_RST       9'h0c8
`define APD_CMD_WR         0
`define APD_CMD_RD         1
`define APD_CMD_OVL        2
`define APD_STAT_BUSY      0
`define APD_STAT_VALID     1
`define APD_STAT_SETTLED   2

`endif

// ==== src/apd_pkg.sv ====
// Types shared by the converter end and the host end of the parallel link.
// Assumes apd_regs.svh carries all numeric constants.
package apd_pkg;

	// ---------------------------------------------------------------
	// State types
	// ---------------------------------------------------------------
	typedef enum {APD_ACTIVE, APD_STANDBY, APD_SHUTDOWN} apd_pwr_e;
	typedef enum {APD_IDLE, APD_ACQ, APD_CONV} apd_phase_e;
	typedef enum {APD_H_IDLE, APD_H_WLOW, APD_H_WHOLD, APD_H_RWAIT, APD_H_RLOW,
		APD_H_RHOLD} apd_host_e;

endpackage

// ==== src/apd_par_if.sv ====
// Byte-wide parallel link between a host and the converter end.
// Assumes both ends run on the same pclk; the shared data wire is resolved here from enables.
`timescale 1ns/100ps

interface apd_par_if;
	logic       cs_n;
	logic       wr_n;
	logic       rd_n;
	logic       upper_byte_select;
	logic       conv_clk;
	logic [7:0] host_data;
	logic       host_data_oe;
	logic [7:0] dev_data;
	logic       dev_data_oe;
	logic       int_n;
	logic [7:0] data;

	// The converter wins if both drive; an undriven bus reads as zero.
	assign data = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'h00);

	modport dev (
		input  cs_n, wr_n, rd_n, upper_byte_select, conv_clk, data,
		output dev_data, dev_data_oe, int_n
	);

	modport host (
		input  data, int_n,
		output cs_n, wr_n, rd_n, upper_byte_select, conv_clk, host_data, host_data_oe
	);
endinterface

// ==== src/apd_dev.sv ====
// Converter end: power-down sequencing, clock-mode choice, conversion timing, result bus.
// Assumes all link pins arrive unsynchronised; the analog input is a 16-bit sample in 1/16 LSB.
//
// How it works
// R1 - Top two control bits choose power-down mode.
// R2 - Power-down keeps bus alive, starts no conversions.
// R3 - Write rising edge wakes from standby.
// R4 - Shutdown waits for running conversion to end.
// R5 - Write rising edge leaves shutdown.
// R6 - Host waits 500us or 50us after wake.
// R7 - Standby entered by a dummy standby conversion.
// R8 - Straight binary, LSB is reference over 4096; bipolar bytes give two's complement codes instead.
// R9 - Frame: 1 write, 3 acquire, 13 convert, 2 read.
// R10 - Host may write next, then read previous.
// R11 - Code 10 internal clock, 11 external clock.
// R12 - Power-down bytes keep the last clock mode.
// R13 - Reset starts in external clock mode.
// R14 - Byte select picks low byte or padded upper.
// R15 - Code 01 standby, 00 shutdown.
`timescale 1ns/100ps
`include "apd_regs.svh"

module apd_dev #(
	parameter int INT_DIV = `APD_INT_DIV
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	apd_par_if.dev           link,
	input  wire logic [15:0] ain,
	output logic      [1:0]  power_state,
	output logic             busy,
	output logic             clk_internal
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Order: [12]=ext clk, [11]=cs_n, [10]=wr_n, [9]=rd_n, [8]=byte select, [7:0]=data.
	logic [12:0] meta_q;
	logic [12:0] sync_q;
	logic        wr_prev_q;
	logic        rd_prev_q;
	logic        ext_prev_q;

	// Two flops per pin; meta_q is read by nothing but sync_q.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q     <= 13'h1e00;
			sync_q     <= 13'h1e00;
			wr_prev_q  <= 1'b1;
			rd_prev_q  <= 1'b1;
			ext_prev_q <= 1'b1;
		end else begin
			meta_q     <= {link.conv_clk, link.cs_n, link.wr_n, link.rd_n,
				link.upper_byte_select, link.data};
			sync_q     <= meta_q;
			wr_prev_q  <= sync_q[10];
			rd_prev_q  <= sync_q[9];
			ext_prev_q <= sync_q[12];
		end
	end

	logic       cs_s;
	logic       ube_s;
	logic [7:0] data_s;
	logic       wr_rise;
	logic       rd_rise;
	logic       ext_rise;

	// A strobe only counts while chip select is low.
	assign cs_s     = ~sync_q[11];
	assign ube_s    = sync_q[8];
	assign data_s   = sync_q[7:0];
	assign wr_rise  = cs_s & sync_q[10] & ~wr_prev_q;
	assign rd_rise  = cs_s & sync_q[9] & ~rd_prev_q;
	assign ext_rise = sync_q[12] & ~ext_prev_q;

	// ---------------------------------------------------------------
	// Result coding
	// ---------------------------------------------------------------
	// Round to the nearest step, so code edges sit halfway between steps, then clamp.
	function automatic logic [11:0] apd_code(input logic [15:0] v, input logic uni);
		logic signed [16:0] r;
		r = (17'(signed'(v)) + 17'sd8) >>> 4;
		if (uni) begin
			if (r < 17'sd0) apd_code = 12'h000;
			else if (r > 17'sd4095) apd_code = 12'hfff;
			else apd_code = r[11:0];
		end else begin
			if (r < -17'sd2048) apd_code = 12'h800;
			else if (r > 17'sd2047) apd_code = 12'h7ff;
			else apd_code = r[11:0];
		end
	endfunction

	// ---------------------------------------------------------------
	// Power, clock mode and conversion sequencing
	// ---------------------------------------------------------------
	apd_pkg::apd_pwr_e   pwr_q, pwr_d;
	apd_pkg::apd_pwr_e   pend_q, pend_d;
	apd_pkg::apd_phase_e phase_q, phase_d;
	logic                pend_valid_q, pend_valid_d;
	logic                clk_int_q, clk_int_d;
	logic                uni_q, uni_d;
	logic [3:0]          cnt_q, cnt_d;
	logic [3:0]          div_q, div_d;
	logic [11:0]         sample_q, sample_d;
	logic [11:0]         result_q, result_d;
	logic                int_n_q, int_n_d;
	logic                tick;
	logic [1:0]          pm;

	assign pm   = data_s[`APD_PM_HI:`APD_PM_LO]; // [R1]
	assign tick = clk_int_q ? (div_q == 4'(INT_DIV - 1)) : ext_rise;

	// Next state of power mode, clock mode and the conversion phase.
	always_comb begin
		pwr_d        = pwr_q;
		pend_d       = pend_q;
		pend_valid_d = pend_valid_q;
		phase_d      = phase_q;
		clk_int_d    = clk_int_q;
		uni_d        = uni_q;
		cnt_d        = cnt_q;
		sample_d     = sample_q;
		result_d     = result_q;
		int_n_d      = int_n_q;
		div_d        = (clk_int_q && div_q != 4'(INT_DIV - 1)) ? div_q + 4'h1 : 4'h0;

		// Finishing the upper byte read releases the end flag; a conversion end below wins.
		if (rd_rise && ube_s) begin
			int_n_d = 1'b1;
		end

		// Phase timing in conversion clocks: acquire 3, then convert 13.
		case (phase_q)
			apd_pkg::APD_IDLE: begin
			end
			apd_pkg::APD_ACQ: begin
				if (tick) begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == `APD_ACQ_CLKS - 4'h1) begin // [R9]
						phase_d  = apd_pkg::APD_CONV;
						cnt_d    = 4'h0;
						sample_d = apd_code(ain, uni_q); // [R8]
					end
				end
			end
			apd_pkg::APD_CONV: begin
				if (tick) begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == `APD_CONV_CLKS - 4'h1) begin // [R9]
						phase_d  = apd_pkg::APD_IDLE;
						cnt_d    = 4'h0;
						result_d = sample_q;
						int_n_d  = 1'b0;
					end
				end
			end
			default: phase_d = apd_pkg::APD_IDLE;
		endcase

		// A requested power-down takes effect once no conversion runs.
		if (pend_valid_q && phase_d == apd_pkg::APD_IDLE) begin // [R4]
			pwr_d        = pend_q;
			pend_valid_d = 1'b0;
		end

		// A write edge wakes the part unless it carries a power-down byte while idle; power-down bytes start nothing.
		if (wr_rise) begin
			pwr_d = apd_pkg::APD_ACTIVE; // [R3] [R5]
			case (pm)
				`APD_PM_INTCLK, `APD_PM_EXTCLK: begin
					clk_int_d    = (pm == `APD_PM_INTCLK); // [R11]
					uni_d        = data_s[`APD_POL_BIT];
					pend_valid_d = 1'b0;
					phase_d      = apd_pkg::APD_ACQ;
					cnt_d        = 4'h0;
				end
				`APD_PM_STBY: begin
					pend_d       = apd_pkg::APD_STANDBY; // [R15] [R2] [R12]
					pend_valid_d = 1'b1;
					uni_d        = data_s[`APD_POL_BIT];
				end
				default: begin
					pend_d       = apd_pkg::APD_SHUTDOWN; // [R15] [R4] [R12]
					pend_valid_d = 1'b1;
					uni_d        = data_s[`APD_POL_BIT];
				end
			endcase
			if (pm[1] == 1'b0 && phase_q == apd_pkg::APD_IDLE) begin
				pwr_d        = pend_d; // [R1]
				pend_valid_d = 1'b0;
			end
		end
	end

	// Registers of the power and conversion group; external clock after reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_q        <= apd_pkg::APD_ACTIVE;
			pend_q       <= apd_pkg::APD_ACTIVE;
			pend_valid_q <= 1'b0;
			phase_q      <= apd_pkg::APD_IDLE;
			clk_int_q    <= 1'b0; // [R13]
			uni_q        <= 1'b1;
			cnt_q        <= 4'h0;
			div_q        <= 4'h0;
			sample_q     <= 12'h000;
			result_q     <= 12'h000;
			int_n_q      <= 1'b1;
		end else begin
			pwr_q        <= pwr_d;
			pend_q       <= pend_d;
			pend_valid_q <= pend_valid_d;
			phase_q      <= phase_d;
			clk_int_q    <= clk_int_d;
			uni_q        <= uni_d;
			cnt_q        <= cnt_d;
			div_q        <= div_d;
			sample_q     <= sample_d;
			result_q     <= result_d;
			int_n_q      <= int_n_d;
		end
	end

	// ---------------------------------------------------------------
	// Read data drive and status outputs
	// ---------------------------------------------------------------
	logic [7:0] dout_q, dout_d;
	logic       doe_q, doe_d;
	logic [1:0] state_q, state_d;
	logic       busy_q, busy_d;

	// The bus answers in every power mode, so a sleeping part still reads back.
	always_comb begin
		doe_d = cs_s & ~sync_q[9]; // [R2]
		if (ube_s) begin
			dout_d = {(uni_q ? 4'h0 : {4{result_q[11]}}), result_q[11:8]}; // [R14]
		end else begin
			dout_d = result_q[7:0]; // [R14]
		end
		case (pwr_q)
			apd_pkg::APD_STANDBY:  state_d = 2'h1;
			apd_pkg::APD_SHUTDOWN: state_d = 2'h2;
			default:               state_d = 2'h0;
		endcase
		busy_d = (phase_q != apd_pkg::APD_IDLE);
	end

	// Output flops, so no pin is driven from a gate.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout_q  <= 8'h00;
			doe_q   <= 1'b0;
			state_q <= 2'h0;
			busy_q  <= 1'b0;
		end else begin
			dout_q  <= dout_d;
			doe_q   <= doe_d;
			state_q <= state_d;
			busy_q  <= busy_d;
		end
	end

	assign link.dev_data    = dout_q;
	assign link.dev_data_oe = doe_q;
	assign link.int_n       = int_n_q;
	assign power_state      = state_q;
	assign busy             = busy_q;
	assign clk_internal     = clk_int_q;

endmodule

// ==== src/apd_host.sv ====
// Host end: APB registers that order control-byte writes and result reads over the link.
// Assumes the converter end answers on the same pclk; link inputs are still synchronised.
`timescale 1ns/100ps
`include "apd_regs.svh"

module apd_host #(
	parameter int WAKE_INT_CYC = `APD_WAKE_INT_CYC,
	parameter int WAKE_EXT_CYC = `APD_WAKE_EXT_CYC,
	parameter int STROBE_CYC   = `APD_STROBE_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	apd_par_if.host          link
);

	// ---------------------------------------------------------------
	// Link input synchronisers and conversion clock divider
	// ---------------------------------------------------------------
	logic [8:0] meta_q;
	logic [8:0] sync_q;
	logic [2:0] div_q;
	logic       cclk_q;

	// Divided conversion clock; it runs free so the converter may count on it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 9'h100;
			sync_q <= 9'h100;
			div_q  <= 3'h0;
			cclk_q <= 1'b0;
		end else begin
			meta_q <= {link.int_n, link.data};
			sync_q <= meta_q;
			div_q  <= (div_q == 3'(`APD_EXT_DIV / 2 - 1)) ? 3'h0 : div_q + 3'h1;
			cclk_q <= (div_q == 3'(`APD_EXT_DIV / 2 - 1)) ? ~cclk_q : cclk_q;
		end
	end

	// ---------------------------------------------------------------
	// Link sequencer and APB registers
	// ---------------------------------------------------------------
	apd_pkg::apd_host_e st_q, st_d;
	logic [7:0]  cnt_q, cnt_d;
	logic [8:0]  ctrl_q, ctrl_d;
	logic        pend_w_q, pend_w_d;
	logic        pend_r_q, pend_r_d;
	logic        ovl_q, ovl_d;
	logic        hi_q, hi_d;
	logic [11:0] res_q, res_d;
	logic        valid_q, valid_d;
	logic        last_pd_q, last_pd_d;
	logic [15:0] wake_q, wake_d;
	logic        cs_n_q, cs_n_d;
	logic        wr_n_q, wr_n_d;
	logic        rd_n_q, rd_n_d;
	logic        oe_q, oe_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic        busy;
	logic        last;
	logic        setup;
	logic        wr_take;

	assign busy  = (st_q != apd_pkg::APD_H_IDLE) | pend_w_q | pend_r_q;
	assign last  = (cnt_q == 8'(STROBE_CYC - 1));
	assign setup = psel & ~penable;
	// A write lands at the edge that completes the access, when pready is seen high.
	assign wr_take = psel & penable & pwrite & pready_q;

	// Next values for the strobe sequencer and the register file.
	always_comb begin
		st_d      = st_q;
		cnt_d     = last ? 8'h00 : cnt_q + 8'h01;
		ctrl_d    = ctrl_q;
		pend_w_d  = pend_w_q;
		pend_r_d  = pend_r_q;
		ovl_d     = ovl_q;
		hi_d      = hi_q;
		res_d     = res_q;
		valid_d   = valid_q;
		last_pd_d = last_pd_q;
		wake_d    = (wake_q != 16'h0000) ? wake_q - 16'h0001 : 16'h0000;
		cs_n_d    = cs_n_q;
		wr_n_d    = wr_n_q;
		rd_n_d    = rd_n_q;
		oe_d      = oe_q;
		prdata_d  = 32'h0000_0000;
		pready_d  = 1'b0;
		pslverr_d = 1'b0;

		case (st_q)
			apd_pkg::APD_H_IDLE: begin
				cnt_d = 8'h00;
				// Normal order reads the old result first; overlap writes first.
				if (pend_w_q && (ovl_q || !pend_r_q)) begin
					st_d      = apd_pkg::APD_H_WLOW;
					cs_n_d    = 1'b0;
					wr_n_d    = 1'b0;
					oe_d      = 1'b1;
					pend_w_d  = 1'b0;
					last_pd_d = ~ctrl_q[`APD_PM_HI];
					if (last_pd_q) begin
						wake_d = ctrl_q[`APD_CTRL_EXTREF] ? 16'(WAKE_EXT_CYC)
							: 16'(WAKE_INT_CYC); // [R6]
					end
				end else if (pend_r_q) begin
					st_d   = apd_pkg::APD_H_RWAIT;
					cs_n_d = 1'b0;
					hi_d   = 1'b0;
				end
			end
			apd_pkg::APD_H_WLOW: begin
				if (last) begin
					st_d   = apd_pkg::APD_H_WHOLD;
					wr_n_d = 1'b1;
				end
			end
			apd_pkg::APD_H_WHOLD: begin
				if (last) begin
					st_d   = apd_pkg::APD_H_IDLE;
					oe_d   = 1'b0;
					cs_n_d = 1'b1;
				end
			end
			apd_pkg::APD_H_RWAIT: begin
				cnt_d = 8'h00;
				// In overlap the previous result is read while the next converts.
				if (ovl_q || !sync_q[8]) begin // [R9] [R10]
					st_d   = apd_pkg::APD_H_RLOW;
					rd_n_d = 1'b0;
				end
			end
			apd_pkg::APD_H_RLOW: begin
				if (last) begin
					st_d   = apd_pkg::APD_H_RHOLD;
					rd_n_d = 1'b1;
					if (hi_q) res_d[11:8] = sync_q[3:0];
					else res_d[7:0] = sync_q[7:0];
				end
			end
			apd_pkg::APD_H_RHOLD: begin
				if (last) begin
					if (!hi_q) begin
						st_d = apd_pkg::APD_H_RWAIT;
						hi_d = 1'b1;
					end else begin
						st_d     = apd_pkg::APD_H_IDLE;
						cs_n_d   = 1'b1;
						pend_r_d = 1'b0;
						valid_d  = 1'b1;
					end
				end
			end
			default: st_d = apd_pkg::APD_H_IDLE;
		endcase

		// APB: decode in setup, answer in the first access cycle; unmapped offsets flag an error.
		if (setup) begin
			pready_d = 1'b1;
			case (paddr)
				`APD_CTRL_OFS: prdata_d = {23'h0, ctrl_q};
				`APD_CMD_OFS:  prdata_d = 32'h0000_0000;
				`APD_STAT_OFS: prdata_d = {29'h0, wake_q == 16'h0000, valid_q, busy};
				`APD_RES_OFS:  prdata_d = {20'h0, res_q};
				default:       pslverr_d = 1'b1;
			endcase
		end

		// Writes are refused while a link sequence runs, so the control byte never moves mid-write.
		if (wr_take && !busy) begin
			case (paddr)
				`APD_CTRL_OFS: ctrl_d = pwdata[8:0]; // [R7]
				`APD_CMD_OFS: begin
					pend_w_d = pwdata[`APD_CMD_WR];
					pend_r_d = pwdata[`APD_CMD_RD];
					ovl_d    = pwdata[`APD_CMD_OVL];
					if (pwdata[`APD_CMD_RD]) valid_d = 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	// Registers of the sequencer and bus slave.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q      <= apd_pkg::APD_H_IDLE;
			cnt_q     <= 8'h00;
			ctrl_q    <= `APD_CTRL_RST;
			pend_w_q  <= 1'b0;
			pend_r_q  <= 1'b0;
			ovl_q     <= 1'b0;
			hi_q      <= 1'b0;
			res_q     <= 12'h000;
			valid_q   <= 1'b0;
			last_pd_q <= 1'b0;
			wake_q    <= 16'h0000;
			cs_n_q    <= 1'b1;
			wr_n_q    <= 1'b1;
			rd_n_q    <= 1'b1;
			oe_q      <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			ctrl_q    <= ctrl_d;
			pend_w_q  <= pend_w_d;
			pend_r_q  <= pend_r_d;
			ovl_q     <= ovl_d;
			hi_q      <= hi_d;
			res_q     <= res_d;
			valid_q   <= valid_d;
			last_pd_q <= last_pd_d;
			wake_q    <= wake_d;
			cs_n_q    <= cs_n_d;
			wr_n_q    <= wr_n_d;
			rd_n_q    <= rd_n_d;
			oe_q      <= oe_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata                 = prdata_q;
	assign pready                 = pready_q;
	assign pslverr                = pslverr_q;
	assign link.cs_n              = cs_n_q;
	assign link.wr_n              = wr_n_q;
	assign link.rd_n              = rd_n_q;
	assign link.upper_byte_select = hi_q;
	assign link.conv_clk          = cclk_q;
	assign link.host_data         = ctrl_q[7:0];
	assign link.host_data_oe      = oe_q;

endmodule

// ==== dv/apd_properties.sv ====
// Concurrent checks on the parallel link between host end and converter end.
// Assumes one pclk domain; signals come straight from the link interface.
`timescale 1ns/100ps

module apd_properties (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       cs_n,
	input wire logic       wr_n,
	input wire logic       rd_n,
	input wire logic       upper_byte_select,
	input wire logic [7:0] host_data,
	input wire logic       host_data_oe,
	input wire logic       dev_data_oe,
	input wire logic       int_n
);
	// ----
	// Link checks
	// ----
	// Reset clears every check, so stale pre-reset values never fire.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	bus_no_fight_a: assert property (!(dev_data_oe && host_data_oe))
		else $error("both ends drive the data bus");
	cs_covers_write_a: assert property (!wr_n |-> !cs_n)
		else $error("write strobe without chip select");
	wr_data_stable_a: assert property (!wr_n && $past(!wr_n) |-> $stable(host_data) && host_data_oe)
		else $error("control byte moved during write");
	wr_width_a: assert property ($fell(wr_n) |=> !wr_n [*7] ##1 wr_n)
		else $error("write strobe width wrong");
	rd_width_a: assert property ($fell(rd_n) |=> !rd_n [*7] ##1 rd_n)
		else $error("read strobe width wrong");
	cs_gap_a: assert property ($rose(cs_n) |-> $past(wr_n) && $past(rd_n))
		else $error("chip select rose during a strobe");
	oe_after_read_a: assert property ($rose(dev_data_oe) |-> $past(!rd_n, 2) && $past(!cs_n, 2))
		else $error("device drove bus without a read");
	int_release_a: assert property ($rose(int_n) |-> upper_byte_select)
		else $error("end flag cleared without upper byte read");

	// Main scenarios seen on the wire.
	cover property ($fell(int_n));
	cover property ($rose(dev_data_oe) && upper_byte_select);
	cover property ($rose(wr_n) && !cs_n);
endmodule

// ==== dv/tb_adc_power_down_and_throughput.sv ====
// Self-checking bench: host end and converter end joined by the link interface.
// Assumes APB drives the host end; the wake timers are shortened for simulation.
`timescale 1ns/100ps

module tb_adc_power_down_and_throughput;
	logic        pclk, presetn, psel, penable, pwrite;
	logic        pready, pslverr, serr, dev_busy, clk_int;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] ain;
	logic [1:0]  pwr;
	logic [7:0]  hi_byte;
	int          errors, check_count, cyc, busy_cyc;

	// ----
	// Structure
	// ----
	apd_par_if link_if ();
	apd_dev i_apd_dev (.pclk(pclk), .presetn(presetn), .link(link_if), .ain(ain),
		.power_state(pwr), .busy(dev_busy), .clk_internal(clk_int));
	apd_host #(.WAKE_INT_CYC(200), .WAKE_EXT_CYC(50)) i_apd_host (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if));
	apd_properties i_props (.pclk(pclk), .presetn(presetn), .cs_n(link_if.cs_n),
		.wr_n(link_if.wr_n), .rd_n(link_if.rd_n), .upper_byte_select(link_if.upper_byte_select),
		.host_data(link_if.host_data), .host_data_oe(link_if.host_data_oe),
		.dev_data_oe(link_if.dev_data_oe), .int_n(link_if.int_n));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// Watchdog, busy length and the last upper byte the converter drove.
	always @(posedge pclk) begin
		cyc++;
		if (dev_busy === 1'b1) busy_cyc++;
		if (link_if.dev_data_oe === 1'b1 && link_if.upper_byte_select === 1'b1) hi_byte = link_if.data;
		if (cyc == 40000) begin
			errors++;
			tally_and_finish();
		end
	end

	// ----
	// Shared tasks
	// ----
	// Enters on a fresh edge so a release and a new setup never share a time step.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task poll(input logic [31:0] m, input logic [31:0] v);
		do apb(1'b0, 12'h008, 32'h0); while ((r & m) !== v);
	endtask

	task dev_idle();
		do @(posedge pclk); while (dev_busy !== 1'b0);
	endtask

	// Full normal frame: control byte, write, read both bytes, fetch the result.
	task conv(input logic [7:0] cb, input logic [15:0] a);
		ain <= a;
		apb(1'b1, 12'h000, {24'h0, cb});
		apb(1'b1, 12'h004, 32'h1);
		poll(32'h1, 32'h0);
		apb(1'b1, 12'h004, 32'h2);
		poll(32'h3, 32'h2);
		apb(1'b0, 12'h00c, 32'h0);
	endtask

	task tally_and_finish();
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ----
	// Scenarios
	// ----
	task t_reset();
		apb(1'b0, 12'h000, 32'h0);
		chk(r, 32'h0000_00c8);
		chk({31'h0, clk_int}, 32'h0);
		chk({30'h0, pwr}, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, serr}, 32'h1);
	endtask

	// Inputs a sixteenth of a step on each side of a transition, then a negative bipolar code.
	task t_codes();
		conv(8'hc8, 16'd19751);
		chk(r & 32'hfff, 32'd1234);
		conv(8'hc8, 16'd19753);
		chk(r & 32'hfff, 32'd1235);
		chk({24'h0, hi_byte}, 32'h04);
		conv(8'h80, 16'hf9c0);
		chk(r & 32'hfff, 32'hf9c);
		chk({24'h0, hi_byte}, 32'hff);
	endtask

	// Internal clock ticks every 5 pclk, external every 6: 16 ticks of busy each.
	task t_clock();
		busy_cyc = 0;
		conv(8'h88, 16'd800);
		chk({31'h0, clk_int}, 32'h1);
		chk({31'h0, busy_cyc inside {[75:85]}}, 32'h1);
		busy_cyc = 0;
		conv(8'hc8, 16'd800);
		chk({31'h0, clk_int}, 32'h0);
		chk({31'h0, busy_cyc inside {[90:104]}}, 32'h1);
		chk(r & 32'hfff, 32'd50);
	endtask

	task t_power();
		conv(8'h88, 16'd160);
		apb(1'b1, 12'h000, 32'h48);
		apb(1'b1, 12'h004, 32'h1);
		poll(32'h1, 32'h0);
		dev_idle();
		chk({30'h0, pwr}, 32'h1);
		chk({31'h0, clk_int}, 32'h1);
		apb(1'b1, 12'h000, 32'h08);
		apb(1'b1, 12'h004, 32'h1);
		poll(32'h1, 32'h0);
		dev_idle();
		chk({30'h0, pwr}, 32'h2);
		apb(1'b1, 12'h004, 32'h6);
		poll(32'h3, 32'h2);
		apb(1'b0, 12'h00c, 32'h0);
		chk(r & 32'hfff, 32'd10);
		chk({30'h0, pwr}, 32'h2);
		chk({31'h0, dev_busy}, 32'h0);
		apb(1'b1, 12'h000, 32'h88);
		apb(1'b1, 12'h004, 32'h1);
		poll(32'h1, 32'h0);
		chk({30'h0, pwr}, 32'h0);
		chk({31'h0, dev_busy}, 32'h1);
		apb(1'b1, 12'h000, 32'h08);
		apb(1'b1, 12'h004, 32'h1);
		poll(32'h1, 32'h0);
		chk({31'h0, dev_busy}, 32'h1);
		chk({30'h0, pwr}, 32'h0);
		dev_idle();
		chk({30'h0, pwr}, 32'h2);
		apb(1'b0, 12'h008, 32'h0);
		chk(r & 32'h4, 32'h0);
		repeat (220) @(posedge pclk);
		apb(1'b0, 12'h008, 32'h0);
		chk(r & 32'h4, 32'h4);
		apb(1'b1, 12'h004, 32'h2);
		poll(32'h3, 32'h2);
		// External reference: the shorter wake wait must be over well before the internal one.
		apb(1'b1, 12'h000, 32'h148);
		apb(1'b1, 12'h004, 32'h1);
		poll(32'h1, 32'h0);
		apb(1'b1, 12'h000, 32'h1c8);
		apb(1'b1, 12'h004, 32'h1);
		poll(32'h1, 32'h0);
		repeat (60) @(posedge pclk);
		apb(1'b0, 12'h008, 32'h0);
		chk(r & 32'h4, 32'h4);
		dev_idle();
	endtask

	// Next control byte goes out before the unread previous result is fetched.
	task t_overlap();
		apb(1'b1, 12'h000, 32'hc8);
		ain <= 16'd3200;
		apb(1'b1, 12'h004, 32'h1);
		poll(32'h1, 32'h0);
		dev_idle();
		ain <= 16'd6400;
		apb(1'b1, 12'h004, 32'h7);
		poll(32'h1, 32'h0);
		apb(1'b0, 12'h00c, 32'h0);
		chk(r & 32'hfff, 32'd200);
		dev_idle();
		apb(1'b1, 12'h004, 32'h2);
		poll(32'h3, 32'h2);
		apb(1'b0, 12'h00c, 32'h0);
		chk(r & 32'hfff, 32'd400);
	endtask

	initial begin
		errors = 0;
		check_count = 0;
		cyc = 0;
		busy_cyc = 0;
		hi_byte = 8'h00;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ain = 16'h0000;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_codes();
		t_clock();
		t_power();
		t_overlap();
		tally_and_finish();
	end
endmodule
